/* rtl/xram_can_access_control.sv */
// Purpose: Route external data moves to on-chip RAM/CAN or external bus
// Assumes: CPU presents one-cycle move requests on clk_sys
// Notes:   Pin level of the external access pin is synchronised here
// Behaviour
// - On-chip RAM sits atop external data space
// - Two kilobytes of extended RAM provided
// - 256-byte CAN window via same path
// - Sixteen-bit, 64 Kbyte external data space
// - Disable clear: on-chip range served internally
// - Disable set: everything goes external
// - Disable bit is one after reset
// - Software cannot set disable bit again
// - Visibility clear: strobes quiet on-chip
// - Visibility set: ports and strobes driven
// - Visibility ignored off-range or disabled
// - Pointer moves on-chip from F700 to FFFF
// - Page register supplies upper byte
// - Port behaviour uses both bits and pin
`timescale 1ns/1ps
`default_nettype none
module xram_can_access_control
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [7:0]  regRdata,
	// CPU move request
	input  wire logic        moveReq,
	input  wire logic        moveWrite,
	input  wire logic        moveWide,
	input  wire logic [15:0] moveAddr,
	input  wire logic [7:0]  moveWdata,
	output logic      [7:0]  moveRdata,
	output logic             moveDone,
	// Pin
	input  wire logic        extAccessPin,
	// External bus
	output logic             extRdStrobe,
	output logic             extWrStrobe,
	output logic             port0Bus,
	output logic             port2Bus,
	output logic      [15:0] extAddr,
	output logic      [7:0]  extWdata,
	// On-chip CAN window
	output logic             canSel,
	output logic             canWrite,
	output logic      [7:0]  canAddr,
	output logic      [7:0]  canWdata,
	input  wire logic [7:0]  canRdata
);
	// Configuration state
	logic        disable_r;          // Global disable
	logic        visible_r;          // Visibility
	logic [7:0]  page_r;             // Page register
	logic [2:0]  pinSync_r;          // Pin synchroniser
	logic        pinLevel_r;         // Filtered pin level
	// Extended RAM, 2 Kbytes
	logic [7:0]  ram [0:xram_access_pkg::RAM_BYTES-1];
	// Decode wires
	logic [15:0] effAddr;
	logic        inRange;
	logic        onChip;
	logic        isCan;
	logic        strobeOn;
	logic        rdPend_r;
	logic        canPend_r;

	// Narrow moves take the upper byte from the page register
	assign effAddr = moveWide ? moveAddr : {page_r, moveAddr[7:0]};
	// Range compare against the top of the space
	assign inRange = (effAddr >= xram_access_pkg::ONCHIP_BASE);
	assign onChip  = inRange && !disable_r;
	assign isCan   = (effAddr <= xram_access_pkg::CAN_LAST);
	// Strobes: off-range always, on-chip only when visible
	assign strobeOn = !onChip || visible_r;

	// Pin synchroniser, change accepted when stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pinSync_r <= 3'h0;
		else if (clkEn)
			pinSync_r <= {pinSync_r[1:0], extAccessPin};
	end

	// Filtered level of the external access pin
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pinLevel_r <= 1'b0;
		else if (clkEn && (pinSync_r[1] == pinSync_r[2]))
			pinLevel_r <= pinSync_r[2];
	end

	// Disable bit: clearable by software, set again only by reset
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			disable_r <= xram_access_pkg::CFG_RESET[xram_access_pkg::BIT_DISABLE];
		else if (clkEn && regWr && regAddr == xram_access_pkg::CFG_OFFSET
			&& !regWdata[xram_access_pkg::BIT_DISABLE])
			disable_r <= 1'b0;
	end

	// Visibility bit, freely written
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			visible_r <= xram_access_pkg::CFG_RESET[xram_access_pkg::BIT_VISIBLE];
		else if (clkEn && regWr && regAddr == xram_access_pkg::CFG_OFFSET)
			visible_r <= regWdata[xram_access_pkg::BIT_VISIBLE];
	end

	// Page register
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			page_r <= xram_access_pkg::PAGE_RESET;
		else if (clkEn && regWr && regAddr == xram_access_pkg::PAGE_OFFSET)
			page_r <= regWdata;
	end

	// Register read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			regRdata <= 8'h00;
		else if (clkEn && regRd)
		begin
			if (regAddr == xram_access_pkg::CFG_OFFSET)
				regRdata <= {6'h00, visible_r, disable_r};
			else if (regAddr == xram_access_pkg::PAGE_OFFSET)
				regRdata <= page_r;
			else
				regRdata <= 8'h00;
		end
		else if (clkEn)
			regRdata <= 8'h00;
	end

	// Extended RAM write; array kept free of reset to map onto memory
	always_ff @(posedge clk_sys)
	begin
		if (clkEn && moveReq && moveWrite && onChip && !isCan)
			ram[effAddr[10:0]] <= moveWdata;
	end

	// Outgoing bus strobes and port ownership, registered
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			extRdStrobe <= 1'b0;
			extWrStrobe <= 1'b0;
			port0Bus    <= 1'b0;
			port2Bus    <= 1'b0;
			extAddr     <= 16'h0000;
			extWdata    <= 8'h00;
		end
		else if (clkEn)
		begin
			extRdStrobe <= moveReq && !moveWrite && strobeOn;
			extWrStrobe <= moveReq && moveWrite && strobeOn;
			// Port 0 carries low address/data unless hidden on-chip with the pin high
			port0Bus <= moveReq && (strobeOn || !pinLevel_r);
			// Port 2 only in wide moves, same pin dependence
			port2Bus <= moveReq && moveWide
				&& (strobeOn || !pinLevel_r);
			if (moveReq)
			begin
				extAddr  <= effAddr;
				extWdata <= moveWdata;
			end
		end
	end

	// CAN window request, registered
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			canSel   <= 1'b0;
			canWrite <= 1'b0;
			canAddr  <= 8'h00;
			canWdata <= 8'h00;
		end
		else if (clkEn)
		begin
			canSel   <= moveReq && onChip && isCan;
			canWrite <= moveReq && moveWrite;
			canAddr  <= effAddr[7:0];
			canWdata <= moveWdata;
		end
	end

	// Read completion tracking
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdPend_r  <= 1'b0;
			canPend_r <= 1'b0;
			moveDone  <= 1'b0;
		end
		else if (clkEn)
		begin
			rdPend_r  <= moveReq && !moveWrite && onChip && !isCan;
			canPend_r <= moveReq && !moveWrite && onChip && isCan;
			moveDone  <= moveReq;
		end
	end

	// On-chip read data; external reads are returned by the bus side
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			moveRdata <= 8'h00;
		else if (clkEn && moveReq && !moveWrite && onChip && !isCan)
			moveRdata <= ram[effAddr[10:0]];
		else if (clkEn && canPend_r)
			moveRdata <= canRdata;
	end

	// Disable bit never rises without a reset
	chk_disable_sticky: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!$past(disable_r) |-> !disable_r)
		else $error("disable bit set by software");

	// Configuration comes out of reset disabled and hidden
	chk_reset_values: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> disable_r && !visible_r
		&& page_r == xram_access_pkg::PAGE_RESET)
		else $error("configuration not at reset value");

	// Hidden on-chip accesses keep the strobes quiet
	chk_hidden_strobes: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && onChip && !visible_r)
		|=> !extRdStrobe && !extWrStrobe)
		else $error("strobe on hidden on-chip access");

	// Visible on-chip reads still pulse the read strobe
	chk_visible_strobes: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && !moveWrite && onChip && visible_r)
		|=> extRdStrobe)
		else $error("visible read lacks strobe");

	// Off-range reads go out whatever the visibility bit says
	chk_off_range: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && !moveWrite && !inRange) |=> extRdStrobe)
		else $error("off-range read without strobe");

	// Writes below the on-chip range are external
	chk_low_external: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && moveWrite
		&& effAddr < xram_access_pkg::ONCHIP_BASE)
		|=> extWrStrobe && !canSel)
		else $error("low address not external");

	// With the disable bit set nothing stays on chip
	chk_disabled_external: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && disable_r)
		|=> !canSel && (extRdStrobe || extWrStrobe))
		else $error("disabled access not external");

	// Lowest on-chip page is the CAN window
	chk_can_select: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && !disable_r
		&& effAddr >= xram_access_pkg::CAN_BASE
		&& effAddr <= xram_access_pkg::CAN_LAST) |=> canSel)
		else $error("CAN window missed");

	// Extended RAM addresses never select the CAN window
	chk_ram_select: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && effAddr >= xram_access_pkg::RAM_BASE)
		|=> !canSel)
		else $error("RAM address selected CAN");

	// Narrow moves: page on the upper byte, port 2 left as I/O
	chk_page_addr: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && !moveWide)
		|=> extAddr[15:8] == $past(page_r) && !port2Bus)
		else $error("narrow move address or port 2 wrong");

	// Wide moves carry the full sixteen-bit address
	chk_wide_addr: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && moveWide) |=> extAddr == $past(moveAddr))
		else $error("wide move address lost");

	// Hidden accesses use the ports only while the pin is low
	chk_pin_ports: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq && onChip && !visible_r)
		|=> port0Bus == !$past(pinLevel_r))
		else $error("port 0 ownership ignores the pin");

	// Every taken move is answered one cycle later
	chk_done_pulse: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && moveReq) |=> moveDone)
		else $error("move not completed");

	// A low clock enable freezes the state
	chk_enable_freeze: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!clkEn |=> $stable(disable_r) && $stable(page_r)
		&& $stable(moveDone) && $stable(pinLevel_r))
		else $error("state moved while clock enable low");
endmodule : xram_can_access_control
`default_nettype wire

/* rtl/xram_access_pkg.sv */
// Purpose: Constants for the on-chip data space access control block
// Assumes: 16-bit external data addresses, 8-bit configuration register
// Notes:   Register offset is the configuration register's own address
package xram_access_pkg;
	localparam logic [7:0]  CFG_OFFSET     = 8'hB1;   // Config register
	localparam int          BIT_DISABLE    = 0;       // Global disable bit
	localparam int          BIT_VISIBLE    = 1;       // Visibility bit
	localparam logic [7:0]  CFG_RESET      = 8'h01;   // Disable set at reset
	localparam logic [7:0]  CFG_WMASK      = 8'h03;   // Implemented bits
	localparam logic [15:0] ONCHIP_BASE    = 16'hF700; // Start of on-chip
	localparam logic [7:0]  ONCHIP_PAGE    = 8'hF7;   // First on-chip page
	localparam logic [15:0] CAN_BASE       = 16'hF700; // CAN window start
	localparam logic [15:0] CAN_LAST       = 16'hF7FF; // CAN window end
	localparam logic [15:0] RAM_BASE       = 16'hF800; // Extended RAM start
	localparam int          RAM_BYTES      = 2048;    // Extended RAM size
	localparam int          CAN_BYTES      = 256;     // CAN window size
	localparam logic [7:0]  PAGE_RESET     = 8'h00;   // Page register reset
	localparam logic [7:0]  PAGE_OFFSET    = 8'h91;   // Page register
endpackage : xram_access_pkg

/* sim/cpu_move_model.sv */
// Purpose: CPU side model issuing external data moves
// Assumes: One move at a time, signals changed after a rising edge
// Notes:   Released address is inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module cpu_move_model
(
	// Clock
	input  wire logic        clk_sys,
	// Move request
	output logic             moveReq,
	output logic             moveWrite,
	output logic             moveWide,
	output logic      [15:0] moveAddr,
	output logic      [7:0]  moveWdata
);
	// Idle request at time zero
	initial
	begin
		moveReq = 1'h0;
		moveWrite = 1'h0;
		moveWide = 1'h1;
		moveAddr = 16'h0000;
		moveWdata = 8'h00;
	end
	// One-cycle move, returns just after the taking edge
	task automatic issue(input logic wd, wr, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge clk_sys);
		moveReq <= 1'h1;
		moveWrite <= wr;
		moveWide <= wd;
		moveAddr <= a;
		moveWdata <= d;
		@(posedge clk_sys);
		moveReq <= 1'h0;
		moveAddr <= ~a;
		moveWdata <= ~d;
		#1;
	endtask : issue
endmodule : cpu_move_model
`default_nettype wire

/* sim/test_xram_can_access_control.sv */
// Purpose: Self-checking bench for the data space access control
// Assumes: Access pin high but for one corner, enable low for one move
// Notes:   Random moves come from a fixed-seed LFSR
`timescale 1ns/1ps
`default_nettype none
module test_xram_can_access_control;
	logic        clk_sys, rst_n, regWr, regRd;   // Clock, reset, strobes
	logic [7:0]  regAddr, regWdata, regRdata, q; // Register port
	logic        moveReq, moveWrite, moveWide, moveDone, canSel, canWrite;
	logic [15:0] moveAddr, extAddr;
	logic [7:0]  moveWdata, moveRdata, extWdata, canAddr, canWdata;
	logic        extRdStrobe, extWrStrobe, port0Bus, port2Bus;
	logic [7:0]  canRdata = 8'h3C;               // CAN side answer
	logic [31:0] rnd = 32'h0001_525D;            // LFSR state
	logic        clkEn = 1'h1, accessPin = 1'h1; // Enable, pin level
	logic [7:0]  page;                           // Shadow page register
	logic        dis, vis;                       // Shadow config bits
	int          errCount = 0, samplesChecked = 0;
	xram_can_access_control u_xram_can_access_control (.clk_sys, .rst_n,
		.clkEn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.moveReq, .moveWrite, .moveWide, .moveAddr, .moveWdata, .moveRdata,
		.moveDone, .extAccessPin(accessPin), .extRdStrobe, .extWrStrobe,
		.port0Bus, .port2Bus, .extAddr, .extWdata, .canSel, .canWrite,
		.canAddr, .canWdata, .canRdata);
	cpu_move_model u_cpu_move_model (.clk_sys, .moveReq, .moveWrite,
		.moveWide, .moveAddr, .moveWdata);
	// Free-running 40 MHz clock
	initial
	begin
		clk_sys = 1'h0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Hang guard, far beyond the expected run
	initial
	begin
		#(25 * 4000);
		errCount++;
		wrapUp();
	end
	function automatic logic [5:0] expMove(input logic [15:0] e,
		input logic wr, wd);
		logic on, s;
		on = (e >= xram_access_pkg::ONCHIP_BASE) && !dis;
		s = !on || vis;   // Strobes hidden only on-chip and invisible
		// A low pin hands the ports to the bus even when hidden
		return {1'h1, !wr && s, wr && s,
			on && e <= xram_access_pkg::CAN_LAST, s || !accessPin,
			(s || !accessPin) && wd};
	endfunction : expMove
	// Next state of the stimulus shift register
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string n, input logic [15:0] seen, exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			errCount++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic regW(input logic [7:0] a, d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'h1;
		@(posedge clk_sys);
		regWr <= 1'h0;
	endtask : regW
	task automatic regR(input logic [7:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge clk_sys);
		regRd <= 1'h0;
		#1 q = regRdata;
	endtask : regR
	// Config write; a cleared disable bit can never come back
	task automatic wcfg(input logic [7:0] d);
		regW(xram_access_pkg::CFG_OFFSET, d);
		vis = d[1];
		dis = dis & d[0];
	endtask : wcfg
	task automatic mv(input logic wd, wr, input logic [15:0] a,
		input logic [7:0] d);
		logic [15:0] e;
		e = wd ? a : {page, a[7:0]};
		u_cpu_move_model.issue(wd, wr, a, d);
		chk("move", {9'h000, canWrite, moveDone, extRdStrobe, extWrStrobe,
			canSel, port0Bus, port2Bus}, {9'h000, wr, expMove(e, wr, wd)});
		chk("extAddr", extAddr, e);
		chk("extWdata", {8'h00, extWdata}, {8'h00, d});
		chk("canBus", {canAddr, canWdata}, {e[7:0], d});
	endtask : mv
	task automatic doReset();
		@(posedge clk_sys);
		rst_n <= 1'h0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'h1;
		{dis, vis, page} = {1'h1, 1'h0, 8'h00};
		regR(xram_access_pkg::CFG_OFFSET);
		chk("config", {8'h00, q}, 16'h0001);
	endtask : doReset
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", samplesChecked, errCount);
		if (errCount == 0 && samplesChecked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrapUp
	// Directed corners, then random traffic, then a second reset
	initial
	begin
		{rst_n, regWr, regRd, regAddr, regWdata} = 19'h0_0000;
		doReset();
		regR(8'h55);
		chk("unmapped", {8'h00, q}, 16'h0000);
		mv(1'h1, 1'h0, 16'hF800, 8'h00);
		wcfg(8'h00);
		wcfg(8'h01);
		regR(xram_access_pkg::CFG_OFFSET);
		chk("config", {8'h00, q}, 16'h0000);
		mv(1'h1, 1'h1, 16'hFFFF, 8'hA5);
		mv(1'h1, 1'h0, 16'hFFFF, 8'h00);
		chk("ramData", {8'h00, moveRdata}, 16'h00A5);
		// Pin low: hidden on-chip moves still own the ports
		@(posedge clk_sys) accessPin <= 1'h0;
		repeat (5) @(posedge clk_sys);
		mv(1'h1, 1'h0, 16'hF800, 8'h00);
		mv(1'h1, 1'h1, 16'hFFFE, 8'h5C);
		@(posedge clk_sys) accessPin <= 1'h1;
		repeat (5) @(posedge clk_sys);
		mv(1'h1, 1'h0, 16'hF700, 8'h00);
		@(posedge clk_sys);
		#1 chk("canData", {8'h00, moveRdata}, 16'h003C);
		mv(1'h1, 1'h0, 16'hF6FF, 8'h00);
		regW(xram_access_pkg::PAGE_OFFSET, 8'hF7);
		page = 8'hF7;
		mv(1'h0, 1'h1, 16'h0010, 8'h11);
		wcfg(8'h02);
		mv(1'h1, 1'h0, 16'hF900, 8'h00);
		// Clock enable low: a move is neither answered nor stored
		mv(1'h1, 1'h1, 16'hF900, 8'h77);
		@(posedge clk_sys) clkEn <= 1'h0;
		u_cpu_move_model.issue(1'h1, 1'h1, 16'hF900, 8'hEE);
		chk("frozen", {15'h0000, moveDone}, 16'h0000);
		@(posedge clk_sys) clkEn <= 1'h1;
		mv(1'h1, 1'h0, 16'hF900, 8'h00);
		chk("ramData", {8'h00, moveRdata}, 16'h0077);
		repeat (60)
		begin
			rnd = lfsr(rnd);
			if (rnd[20])
				wcfg({6'h00, rnd[19], 1'h0});
			if (rnd[21])
				regW(xram_access_pkg::PAGE_OFFSET, rnd[31:24]);
			if (rnd[21])
				page = rnd[31:24];
			mv(rnd[18], rnd[17], {rnd[16] ? 4'hF : rnd[15:12], rnd[11:0]},
				rnd[7:0]);
		end
		doReset();
		mv(1'h1, 1'h1, 16'hF800, 8'h5A);
		wrapUp();
	end
endmodule : test_xram_can_access_control
`default_nettype wire
